// >>> bench/dcpf_fabric_port.sv
// Fabric-side model of one FIFO port: one port clock pulse framed by select and strobe
`timescale 1ns/1ps
module dcpf_fabric_port (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_go,
	input wire dcpf_pkg::dcpf_word_t i_word,
	output logic o_clk,
	output logic o_sel_n,
	output logic o_str_n,
	output dcpf_pkg::dcpf_word_t o_word
);
	import dcpf_pkg::*;
	logic [1:0] phase;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			phase <= 2'h0;
			o_word <= '0;
		end else if (phase != 2'h0 || i_go) begin
			phase <= phase + 2'h1;
			// Released word turns to its inverse so stale data is never taken as valid
			o_word <= (phase == 2'h0) ? i_word : ((phase == 2'h2) ? ~o_word : o_word);
		end
	end
	// Clock stands low between frames
	assign o_clk = (phase == 2'h2);
	assign o_sel_n = !(phase == 2'h1 || phase == 2'h2);
	assign o_str_n = o_sel_n;
endmodule

// >>> bench/dcpf_top_asserts.sv
// Concurrent checks on the FIFO top-level ports
`timescale 1ns/1ps
module dcpf_top_asserts (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire dcpf_pkg::dcpf_resp_t o_bresp,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] o_rdata,
	input wire dcpf_pkg::dcpf_resp_t o_rresp,
	input wire logic i_ptr_reset_n,
	input wire logic o_full,
	input wire logic o_empty,
	input wire logic o_count_equals_threshold,
	input wire logic o_count_at_least_threshold
);
	import dcpf_pkg::*;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	sequence ptr_clear;
		!i_ptr_reset_n ##1 !i_ptr_reset_n;
	endsequence
	sequence aw_w_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	chk_flag_excl: assert property (!(o_full && o_empty))
		else $error("full and empty together");
	chk_eq_geq: assert property (o_count_equals_threshold |-> o_count_at_least_threshold)
		else $error("equal flag without at-least flag");
	chk_ptr_empty: assert property (ptr_clear |=> o_empty)
		else $error("pointer clear left data");
	chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	chk_read_hold: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata) && $stable(o_rresp))
		else $error("read answer moved");
	chk_resp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer moved");
	chk_write_answer: assert property (aw_w_taken |-> ##2 o_bvalid)
		else $error("write answer not two cycles later");
	chk_read_block: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("read answer stayed after it was taken");
endmodule
bind dcpf_top dcpf_top_asserts u_asserts (.i_mclk, .i_rst_n, .i_awvalid, .o_awready,
	.i_wvalid, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid,
	.i_rready, .o_rdata, .o_rresp, .i_ptr_reset_n, .o_full, .o_empty,
	.o_count_equals_threshold, .o_count_at_least_threshold);

// >>> bench/testbench.sv
// Self-checking bench for the dual clock parity FIFO
`timescale 1ns/1ps
module testbench;
	import dcpf_pkg::*;
	logic i_mclk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic i_ptr_reset_n, wgo, rgo, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_full, o_empty, o_irq, o_count_equals_threshold, o_count_at_least_threshold;
	logic o_read_parity_fault, o_write_parity_fault;
	logic i_write_side_clock, i_write_select_n, i_write_strobe_n;
	logic i_read_side_clock, i_read_select_n, i_read_strobe_n;
	dcpf_addr_t i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, rd;
	logic [3:0] i_wstrb;
	logic [1:0] rr;
	dcpf_word_t wword, i_write_word, o_read_word;
	dcpf_out_t i_cascade_in;
	dcpf_resp_t o_bresp, o_rresp;
	int mismatches = 0;
	int cmp_count = 0;
	dcpf_fabric_port wport (.i_mclk, .i_rst_n, .i_go(wgo), .i_word(wword),
		.o_clk(i_write_side_clock), .o_sel_n(i_write_select_n), .o_str_n(i_write_strobe_n),
		.o_word(i_write_word));
	dcpf_fabric_port rport (.i_mclk, .i_rst_n, .i_go(rgo), .i_word(wword),
		.o_clk(i_read_side_clock), .o_sel_n(i_read_select_n), .o_str_n(i_read_strobe_n),
		.o_word());
	dcpf_top i_dut (.i_mclk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
		.i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
		.o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_write_side_clock, .i_read_side_clock,
		.i_write_select_n, .i_write_strobe_n, .i_write_word, .i_read_select_n,
		.i_read_strobe_n, .i_ptr_reset_n, .i_cascade_in, .o_read_word, .o_full, .o_empty,
		.o_count_equals_threshold, .o_count_at_least_threshold, .o_read_parity_fault,
		.o_write_parity_fault, .o_irq);
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	task automatic finish_test();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One AXI4-Lite transfer; each channel drops its valid only after its own handshake
	task automatic axi(input logic wr, input dcpf_addr_t a, input logic [31:0] d);
		logic [4:0] tk;
		int n;
		n = 0;
		@(posedge i_mclk);
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {{3{wr}}, {2{!wr}}};
		i_awaddr <= a;
		i_araddr <= a;
		i_wdata <= d;
		do begin
			@(negedge i_mclk);
			tk = {i_awvalid & o_awready, i_wvalid & o_wready, i_bready & o_bvalid,
				i_arvalid & o_arready, i_rready & o_rvalid};
			if (tk[0]) {rd, rr} = {o_rdata, o_rresp};
			if (tk[2]) rr = o_bresp;
			@(posedge i_mclk);
			{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <=
				{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} & ~tk;
			n++;
			if (n > 64) begin
				mismatches++;
				finish_test();
			end
		end while ({i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} != 5'h0);
		@(negedge i_mclk);
	endtask
	// Outputs lag the port take by two cycles, so the wait covers that and settles
	task automatic port_op(input logic rd_op, input dcpf_word_t w);
		@(posedge i_mclk);
		rgo <= rd_op;
		wgo <= !rd_op;
		wword <= w;
		@(posedge i_mclk);
		rgo <= 1'b0;
		wgo <= 1'b0;
		repeat (5) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask
	task automatic t_reset();
		axi(1'b0, 8'h00, 32'h0);
		check("ctrl", rd, 32'h0000001c);
		check("ctrl resp", rr, 2'h0);
		axi(1'b0, 8'h04, 32'h0);
		check("status", rd[3:0], 4'he);
		axi(1'b0, 8'h14, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped resp", rr, 2'h2);
		axi(1'b1, 8'h14, 32'hffffffff);
		check("unmapped wr resp", rr, 2'h2);
		check("irq idle", o_irq, 1'b0);
	endtask
	task automatic t_fill();
		axi(1'b1, 8'h00, 32'h00000204);
		for (int i = 0; i < 4; i++) begin
			port_op(1'b0, 9'(17 * (i + 1)));
			check("eq", o_count_equals_threshold, i == 1);
			check("geq", o_count_at_least_threshold, i >= 1);
			check("full", o_full, i == 3);
		end
		port_op(1'b0, 9'h1ff);
		axi(1'b0, 8'h04, 32'h0);
		check("count", rd[24:16], 9'h004);
		axi(1'b0, 8'h08, 32'h0);
		check("irq set", rd[2], 1'b1);
		check("irq masked", o_irq, 1'b0);
		axi(1'b1, 8'h0c, 32'h00000004);
		check("irq on", o_irq, 1'b1);
		axi(1'b1, 8'h08, 32'h00000004);
		check("irq off", o_irq, 1'b0);
	endtask
	task automatic t_drain();
		for (int i = 0; i < 4; i++) begin
			port_op(1'b1, 9'h000);
			check("word", o_read_word, 17 * (i + 1));
			check("rfault", o_read_parity_fault, 1'b0);
			check("empty", o_empty, i == 3);
		end
		port_op(1'b1, 9'h000);
		check("held", o_read_word, 9'h044);
		axi(1'b0, 8'h08, 32'h0);
		check("irq empty", rd[3], 1'b1);
	endtask
	task automatic t_parity();
		for (int odd = 0; odd < 2; odd++) begin
			axi(1'b1, 8'h00, 32'h205 | 32'(odd << 1));
			port_op(1'b0, 9'h1a7);
			check("wfault gen", o_write_parity_fault, 1'b0);
			port_op(1'b1, 9'h000);
			check("gen word", o_read_word, {^8'ha7 ^ odd[0], 8'ha7});
			axi(1'b1, 8'h00, 32'h204 | 32'(odd << 1));
			port_op(1'b0, 9'h001);
			check("wfault", o_write_parity_fault, !odd[0]);
			port_op(1'b1, 9'h000);
			check("rfault", o_read_parity_fault, !odd[0]);
		end
	endtask
	task automatic t_ptr_cascade();
		port_op(1'b0, 9'h003);
		port_op(1'b0, 9'h005);
		@(posedge i_mclk);
		i_ptr_reset_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_ptr_reset_n <= 1'b1;
		repeat (2) @(negedge i_mclk);
		check("ptr empty", o_empty, 1'b1);
		port_op(1'b0, 9'h003);
		axi(1'b0, 8'h10, 32'h0);
		check("wr ptr", rd, 32'h00000001);
		// Soft pointer clear through the control register
		axi(1'b1, 8'h00, 32'h00000244);
		axi(1'b0, 8'h10, 32'h0);
		check("pointers", rd, 32'h0);
		axi(1'b1, 8'h00, 32'h00000224);
		repeat (2) @(negedge i_mclk);
		check("casc word", o_read_word, 9'h0a5);
		check("casc empty", o_empty, 1'b0);
	endtask
	initial begin
		{i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, wgo, rgo} = 8'h00;
		i_awaddr = '0;
		i_araddr = '0;
		i_wdata = '0;
		i_wstrb = 4'hf;
		wword = '0;
		i_ptr_reset_n = 1'b1;
		i_cascade_in = {9'h0a5, 6'h03};
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset();
		t_fill();
		t_drain();
		t_parity();
		t_ptr_cascade();
		finish_test();
	end
endmodule

// >>> hw/dcpf_axil_slave.sv
// AXI4-Lite slave front end for the FIFO register file
`timescale 1ns/1ps
module dcpf_axil_slave (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire dcpf_pkg::dcpf_addr_t i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output dcpf_pkg::dcpf_resp_t o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire dcpf_pkg::dcpf_addr_t i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output dcpf_pkg::dcpf_resp_t o_rresp,
	dcpf_reg_if.bus rif
);
	import dcpf_pkg::*;
	logic aw_full;
	logic w_full;
	dcpf_addr_t aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_wr;

	// Address and data are parked separately, so either may arrive first
	assign o_awready = ~aw_full & ~o_bvalid;
	assign o_wready = ~w_full & ~o_bvalid;
	assign o_arready = ~o_rvalid;
	assign do_wr = aw_full & w_full & ~o_bvalid;
	assign rif.wr_en = do_wr;
	assign rif.wr_addr = aw_addr;
	assign rif.wr_data = w_data;
	assign rif.wr_strb = w_strb;
	assign rif.rd_addr = i_araddr;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end else if (i_awvalid && o_awready) begin
			aw_full <= 1'b1;
			aw_addr <= i_awaddr;
		end else if (do_wr) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			w_full <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (i_wvalid && o_wready) begin
			w_full <= 1'b1;
			w_data <= i_wdata;
			w_strb <= i_wstrb;
		end else if (do_wr) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_bvalid <= 1'b0;
			o_bresp <= DCPF_RESP_OKAY;
		end else if (do_wr) begin
			o_bvalid <= 1'b1;
			o_bresp <= rif.wr_hit ? DCPF_RESP_OKAY : DCPF_RESP_SLVERR;
		end else if (o_bvalid && i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= DCPF_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata <= rif.rd_data;
			o_rresp <= rif.rd_hit ? DCPF_RESP_OKAY : DCPF_RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule

// >>> hw/dcpf_cascade_mux.sv
// Registered per-signal output selector used when FIFO blocks are cascaded
`timescale 1ns/1ps
`include "dcpf_params.svh"
module dcpf_cascade_mux (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_select,
	input wire dcpf_pkg::dcpf_out_t i_local,
	input wire dcpf_pkg::dcpf_out_t i_cascade,
	output dcpf_pkg::dcpf_out_t o_out
);
	import dcpf_pkg::*;
	localparam dcpf_out_t OUT_RESET = `DCPF_OUT_RESET;

	// One selector per output signal, no shared logic between bits
	for (genvar i = 0; i < `DCPF_OUT_W; i++) begin : g_bit
		always_ff @(posedge i_mclk) begin
			if (!i_rst_n) begin
				o_out[i] <= OUT_RESET[i];
			end else begin
				o_out[i] <= i_select ? i_cascade[i] : i_local[i];
			end
		end
	end
endmodule

// >>> hw/dcpf_params.svh
// Constants for the dual clock parity FIFO: sizes, register map, fields, reset values
`ifndef DCPF_PARAMS_SVH
`define DCPF_PARAMS_SVH
`define DCPF_WORD_W 9
`define DCPF_IDX_W 8
`define DCPF_PTR_W 9
`define DCPF_MAX_DEPTH 256
`define DCPF_THR_W 8
`define DCPF_EXP_W 3
`define DCPF_OUT_W 15
`define DCPF_OUT_RESET 15'h0007
`define DCPF_AXI_AW 8
`define DCPF_OFF_CTRL 8'h00
`define DCPF_OFF_STATUS 8'h04
`define DCPF_OFF_IRQ_STATUS 8'h08
`define DCPF_OFF_IRQ_MASK 8'h0c
`define DCPF_OFF_POINTERS 8'h10
`define DCPF_CTRL_PGEN 0
`define DCPF_CTRL_ODD 1
`define DCPF_CTRL_EXP_LSB 2
`define DCPF_CTRL_CASC 5
`define DCPF_CTRL_SOFT_RST 6
`define DCPF_CTRL_THR_LSB 8
`define DCPF_CTRL_MASK 32'h0000ff3f
`define DCPF_CTRL_RESET 32'h0000001c
`define DCPF_ST_FULL 0
`define DCPF_ST_EMPTY 1
`define DCPF_ST_EQ 2
`define DCPF_ST_GEQ 3
`define DCPF_ST_WPE 4
`define DCPF_ST_RPE 5
`define DCPF_ST_COUNT_LSB 16
`define DCPF_PTRS_RD_LSB 16
`define DCPF_IRQ_W 7
`define DCPF_IRQ_WPE 0
`define DCPF_IRQ_RPE 1
`define DCPF_IRQ_WBLK 2
`define DCPF_IRQ_RBLK 3
`define DCPF_IRQ_THR 4
`define DCPF_IRQ_FULL 5
`define DCPF_IRQ_EMPTY 6
`endif

// >>> hw/dcpf_pkg.sv
// Types shared by the dual clock parity FIFO modules
package dcpf_pkg;
`include "dcpf_params.svh"
	typedef logic [`DCPF_WORD_W-1:0] dcpf_word_t;
	typedef logic [`DCPF_PTR_W-1:0] dcpf_ptr_t;
	typedef logic [`DCPF_AXI_AW-1:0] dcpf_addr_t;
	typedef logic [`DCPF_OUT_W-1:0] dcpf_out_t;
	typedef enum logic [1:0] {DCPF_RESP_OKAY = 2'h0, DCPF_RESP_SLVERR = 2'h2} dcpf_resp_t;
endpackage

// >>> hw/dcpf_reg_if.sv
// Register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface dcpf_reg_if;
	import dcpf_pkg::*;
	logic wr_en;
	dcpf_addr_t wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	dcpf_addr_t rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	modport bus (
		output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_hit, rd_data, rd_hit
	);
	modport regs (
		input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_hit, rd_data, rd_hit
	);
endinterface

// >>> hw/dcpf_top.sv
// Dual clock parity FIFO with AXI4-Lite configuration and interrupt
//
// Function
// R01 - Write and read act on their own clocks
// R02 - Read needs read select driven low
// R03 - Write needs write select driven low
// R04 - Pointer reset low clears both pointers
// R05 - Generation replaces input MSB with parity
// R06 - Output MSB carries the parity bit
// R07 - Full blocks writes, empty blocks reads
// R08 - Equal flag when count equals threshold
// R09 - At-least flag when count reaches threshold
// R10 - Threshold is held static while running
// R11 - Depth is two to exponent plus one
// R12 - Low sense even parity, high odd
// R13 - Read side parity fault, active high
// R14 - Write side parity fault, active high
// R15 - Each output has its own cascade mux
// R16 - Write on edge with select, strobe, not full
// R17 - Read on edge with select, strobe, not empty
// R18 - Flags from registered pointers, never glitching
`timescale 1ns/1ps
`include "dcpf_params.svh"
module dcpf_top (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire dcpf_pkg::dcpf_addr_t i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output dcpf_pkg::dcpf_resp_t o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire dcpf_pkg::dcpf_addr_t i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output dcpf_pkg::dcpf_resp_t o_rresp,
	input wire logic i_write_side_clock,
	input wire logic i_read_side_clock,
	input wire logic i_write_select_n,
	input wire logic i_write_strobe_n,
	input wire dcpf_pkg::dcpf_word_t i_write_word,
	input wire logic i_read_select_n,
	input wire logic i_read_strobe_n,
	input wire logic i_ptr_reset_n,
	input wire dcpf_pkg::dcpf_out_t i_cascade_in,
	output dcpf_pkg::dcpf_word_t o_read_word,
	output logic o_full,
	output logic o_empty,
	output logic o_count_equals_threshold,
	output logic o_count_at_least_threshold,
	output logic o_read_parity_fault,
	output logic o_write_parity_fault,
	output logic o_irq
);
	import dcpf_pkg::*;

	dcpf_reg_if rif();

	logic [31:0] ctrl;
	logic [`DCPF_IRQ_W-1:0] irq_status;
	logic [`DCPF_IRQ_W-1:0] irq_mask;
	logic [`DCPF_IRQ_W-1:0] irq_event;
	logic [`DCPF_IRQ_W-1:0] irq_clear;
	logic parity_generate_enable;
	logic odd_parity_select;
	logic [`DCPF_EXP_W-1:0] depth_exponent;
	logic cascade_output_mux;
	logic [`DCPF_THR_W-1:0] threshold;
	logic soft_ptr_reset;
	logic ptr_clear;
	logic wclk_q;
	logic rclk_q;
	logic write_edge;
	logic read_edge;
	logic write_request;
	logic read_request;
	logic wr_take;
	logic rd_take;
	dcpf_ptr_t wptr;
	dcpf_ptr_t rptr;
	dcpf_ptr_t count;
	dcpf_ptr_t depth;
	logic [`DCPF_IDX_W-1:0] addr_mask;
	logic [`DCPF_IDX_W-1:0] waddr;
	logic [`DCPF_IDX_W-1:0] raddr;
	dcpf_word_t mem [0:`DCPF_MAX_DEPTH-1];
	dcpf_word_t stored_word;
	dcpf_word_t head_word;
	dcpf_word_t rdata_q;
	logic gen_parity;
	logic wr_bad;
	logic rd_bad;
	logic wpe_q;
	logic rpe_q;
	logic full;
	logic empty;
	logic eq;
	logic geq;
	logic full_q;
	logic empty_q;
	logic geq_q;
	logic ctrl_we;
	logic mask_we;
	logic status_we;
	dcpf_addr_t wr_word_addr;
	dcpf_addr_t rd_word_addr;
	logic [31:0] status_word;
	dcpf_out_t local_out;
	dcpf_out_t muxed_out;

	function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		return res;
	endfunction

	// A word is in error when its ones count disagrees with the sense
	function automatic logic parity_bad(input dcpf_word_t w, input logic odd);
		return (^w) ^ odd;
	endfunction

	dcpf_axil_slave u_bus (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.o_bresp(o_bresp),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.i_araddr(i_araddr),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.rif(rif)
	);

	assign parity_generate_enable = ctrl[`DCPF_CTRL_PGEN];
	assign odd_parity_select = ctrl[`DCPF_CTRL_ODD];
	assign depth_exponent = ctrl[`DCPF_CTRL_EXP_LSB +: `DCPF_EXP_W];
	assign cascade_output_mux = ctrl[`DCPF_CTRL_CASC];
	assign threshold = ctrl[`DCPF_CTRL_THR_LSB +: `DCPF_THR_W];

	// Both port clocks are sampled on the system clock; rising edge acts
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			wclk_q <= 1'b1;
			rclk_q <= 1'b1;
		end else begin
			wclk_q <= i_write_side_clock;
			rclk_q <= i_read_side_clock;
		end
	end
	assign write_edge = i_write_side_clock & ~wclk_q; // R01
	assign read_edge = i_read_side_clock & ~rclk_q; // R01

	assign write_request = write_edge & ~i_write_select_n & ~i_write_strobe_n; // R03
	assign read_request = read_edge & ~i_read_select_n & ~i_read_strobe_n; // R02
	assign wr_take = write_request & ~full; // R07 R16
	assign rd_take = read_request & ~empty; // R07 R17

	// Depth exponent widened first so that the top setting reaches 256
	assign depth = dcpf_ptr_t'(1) << ({1'b0, depth_exponent} + 4'h1); // R11
	assign addr_mask = depth[`DCPF_IDX_W-1:0] - 8'h01; // R11
	assign count = wptr - rptr;
	assign waddr = wptr[`DCPF_IDX_W-1:0] & addr_mask;
	assign raddr = rptr[`DCPF_IDX_W-1:0] & addr_mask;

	// Flags come only from flopped pointers and ctrl fields, one update per edge
	assign full = count >= depth; // R07 R18
	assign empty = count == dcpf_ptr_t'(0); // R07 R18
	assign eq = count == {1'b0, threshold}; // R08 R18
	assign geq = count >= {1'b0, threshold}; // R09 R18

	assign ptr_clear = ~i_ptr_reset_n | soft_ptr_reset;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || ptr_clear) begin
			wptr <= '0; // R04
		end else if (wr_take) begin
			wptr <= wptr + dcpf_ptr_t'(1); // R16
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || ptr_clear) begin
			rptr <= '0; // R04
		end else if (rd_take) begin
			rptr <= rptr + dcpf_ptr_t'(1); // R17
		end
	end

	assign gen_parity = (^i_write_word[`DCPF_WORD_W-2:0]) ^ odd_parity_select; // R12
	always_comb begin
		stored_word = i_write_word;
		if (parity_generate_enable) begin
			stored_word[`DCPF_WORD_W-1] = gen_parity; // R05
		end
	end

	// Storage is left unreset; only words behind valid pointers are read
	always_ff @(posedge i_mclk) begin
		if (wr_take) begin
			mem[waddr] <= stored_word;
		end
	end

	assign head_word = mem[raddr];
	assign wr_bad = ~parity_generate_enable & parity_bad(i_write_word, odd_parity_select); // R12
	assign rd_bad = parity_bad(head_word, odd_parity_select); // R12

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rdata_q <= '0;
			rpe_q <= 1'b0;
		end else if (rd_take) begin
			rdata_q <= head_word; // R06 R17
			rpe_q <= rd_bad; // R13
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			wpe_q <= 1'b0;
		end else if (wr_take) begin
			wpe_q <= wr_bad; // R14
		end
	end

	assign local_out = {rdata_q, rpe_q, wpe_q, full, empty, eq, geq};

	dcpf_cascade_mux u_mux (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_select(cascade_output_mux),
		.i_local(local_out),
		.i_cascade(i_cascade_in),
		.o_out(muxed_out)
	);
	assign {o_read_word, o_read_parity_fault, o_write_parity_fault, o_full, o_empty,
		o_count_equals_threshold, o_count_at_least_threshold} = muxed_out; // R15

	// Register decode ignores the byte offset inside a word
	assign wr_word_addr = {rif.wr_addr[`DCPF_AXI_AW-1:2], 2'b00};
	assign rd_word_addr = {rif.rd_addr[`DCPF_AXI_AW-1:2], 2'b00};

	always_comb begin
		ctrl_we = 1'b0;
		mask_we = 1'b0;
		status_we = 1'b0;
		rif.wr_hit = 1'b1;
		if (wr_word_addr == `DCPF_OFF_CTRL) begin
			ctrl_we = rif.wr_en;
		end else if (wr_word_addr == `DCPF_OFF_IRQ_STATUS) begin
			status_we = rif.wr_en;
		end else if (wr_word_addr == `DCPF_OFF_IRQ_MASK) begin
			mask_we = rif.wr_en;
		end else if (wr_word_addr == `DCPF_OFF_STATUS) begin
			rif.wr_hit = 1'b1;
		end else if (wr_word_addr == `DCPF_OFF_POINTERS) begin
			rif.wr_hit = 1'b1;
		end else begin
			rif.wr_hit = 1'b0;
		end
	end

	always_comb begin
		status_word = '0;
		status_word[`DCPF_ST_FULL] = full;
		status_word[`DCPF_ST_EMPTY] = empty;
		status_word[`DCPF_ST_EQ] = eq;
		status_word[`DCPF_ST_GEQ] = geq;
		status_word[`DCPF_ST_WPE] = wpe_q;
		status_word[`DCPF_ST_RPE] = rpe_q;
		status_word[`DCPF_ST_COUNT_LSB +: `DCPF_PTR_W] = count;
	end

	always_comb begin
		rif.rd_data = '0;
		rif.rd_hit = 1'b1;
		if (rd_word_addr == `DCPF_OFF_CTRL) begin
			rif.rd_data = ctrl;
		end else if (rd_word_addr == `DCPF_OFF_STATUS) begin
			rif.rd_data = status_word;
		end else if (rd_word_addr == `DCPF_OFF_IRQ_STATUS) begin
			rif.rd_data[`DCPF_IRQ_W-1:0] = irq_status;
		end else if (rd_word_addr == `DCPF_OFF_IRQ_MASK) begin
			rif.rd_data[`DCPF_IRQ_W-1:0] = irq_mask;
		end else if (rd_word_addr == `DCPF_OFF_POINTERS) begin
			rif.rd_data[`DCPF_PTR_W-1:0] = wptr;
			rif.rd_data[`DCPF_PTRS_RD_LSB +: `DCPF_PTR_W] = rptr;
		end else begin
			rif.rd_hit = 1'b0;
		end
	end

	// Threshold and depth are meant to stay put while words are stored
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ctrl <= `DCPF_CTRL_RESET;
		end else if (ctrl_we) begin
			ctrl <= apply_strb(ctrl, rif.wr_data, rif.wr_strb) & `DCPF_CTRL_MASK; // R10
		end
	end

	// Self-clearing: a one written here pulses the pointer clear for one cycle, emptying the FIFO
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			soft_ptr_reset <= 1'b0;
		end else begin
			soft_ptr_reset <= ctrl_we & rif.wr_strb[0] & rif.wr_data[`DCPF_CTRL_SOFT_RST]; // R04
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			irq_mask <= '0;
		end else if (mask_we && rif.wr_strb[0]) begin
			irq_mask <= rif.wr_data[`DCPF_IRQ_W-1:0];
		end
	end

	// Previous flag values; reset matches the flags of an empty FIFO
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			full_q <= 1'b0;
			empty_q <= 1'b1;
			geq_q <= 1'b1;
		end else begin
			full_q <= full;
			empty_q <= empty;
			geq_q <= geq;
		end
	end

	always_comb begin
		irq_event = '0;
		irq_event[`DCPF_IRQ_WPE] = wr_take & wr_bad;
		irq_event[`DCPF_IRQ_RPE] = rd_take & rd_bad;
		irq_event[`DCPF_IRQ_WBLK] = write_request & full; // R07
		irq_event[`DCPF_IRQ_RBLK] = read_request & empty; // R07
		irq_event[`DCPF_IRQ_THR] = geq & ~geq_q;
		irq_event[`DCPF_IRQ_FULL] = full & ~full_q;
		irq_event[`DCPF_IRQ_EMPTY] = empty & ~empty_q;
	end

	assign irq_clear = status_we && rif.wr_strb[0] ? rif.wr_data[`DCPF_IRQ_W-1:0] : '0;

	// A new event outranks a clear landing in the same cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_event;
		end
	end

	assign o_irq = |(irq_status & irq_mask);
endmodule
